// ==== obc_pkg.sv ====
// Constants, field layouts and carrier types for the option byte decoder.
// Assumes a byte-wide access port into the option byte row and one 200 MHz clock.
`default_nettype none
package obc_pkg;

   // Byte addresses of the option bytes in the data EEPROM address space.
   localparam logic [15:0] OBC_ADDR_PROTECTION = 16'h4800;
   localparam logic [15:0] OBC_ADDR_BOOT_SIZE = 16'h4802;
   localparam logic [15:0] OBC_ADDR_EEPROM_SIZE = 16'h4803;
   localparam logic [15:0] OBC_ADDR_RESERVED = 16'h4807;
   localparam logic [15:0] OBC_ADDR_WATCHDOG = 16'h4808;

   // Index of each byte in the stored row.
   localparam int OBC_ROW_BYTES = 5;
   localparam logic [2:0] OBC_IDX_PROTECTION = 3'h0;
   localparam logic [2:0] OBC_IDX_BOOT_SIZE = 3'h1;
   localparam logic [2:0] OBC_IDX_EEPROM_SIZE = 3'h2;
   localparam logic [2:0] OBC_IDX_RESERVED = 3'h3;
   localparam logic [2:0] OBC_IDX_WATCHDOG = 3'h4;

   // Factory default of every option byte.
   localparam logic [7:0] OBC_BYTE_DEFAULT = 8'h00;

   // Code that turns readout protection on.
   localparam logic [7:0] OBC_READOUT_LOCK_CODE = 8'hAA;

   // Boot area size field: seven used bits, first size with a write-protected boot area.
   localparam int OBC_BOOT_SIZE_BITS = 7;
   localparam logic [6:0] OBC_BOOT_FIRST_PROTECTED = 7'h03;
   localparam logic [6:0] OBC_BOOT_VECTOR_PAGES = 7'h02;

   // Data EEPROM size field: six used bits, area ends at a fixed top.
   localparam int OBC_EEPROM_SIZE_BITS = 6;
   localparam int OBC_PAGE_SHIFT = 6;
   localparam logic [15:0] OBC_EEPROM_TOP = 16'h9FFF;
   localparam logic [15:0] OBC_EEPROM_END = 16'hA000;

   // Bit positions inside the watchdog option byte.
   localparam int OBC_WDG_AUTO_START_BIT = 0;
   localparam int OBC_WDG_HALT_FREEZE_BIT = 1;

   // Decoded configuration handed to protection, partition and watchdog logic.
   typedef struct packed {
      logic readout_protect;
      logic boot_present;
      logic boot_vectors_only;
      logic boot_write_protect;
      logic [6:0] boot_pages;
      logic eeprom_present;
      logic [5:0] eeprom_pages;
      logic [15:0] eeprom_base;
      logic watchdog_auto_start;
      logic watchdog_halt_freeze;
   } obc_cfg_t;

   // Loader states.
   typedef enum logic {
      OBC_LOAD,
      OBC_HOLD
   } obc_state_t;

endpackage
`default_nettype wire

// ==== obc_option_decoder.sv ====
// Option byte row storage, its guarded access port and the reset-time decoder.
// Assumes the access port is driven synchronously to clk and that dev_rst_req
// is a one-cycle pulse marking every device reset after power-on.
`timescale 1ns/1ps
`default_nettype none

module obc_option_decoder
   import obc_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   // Clock and power-on reset.
   input wire logic clk,
   input wire logic arst_n,
   // Device reset request, one cycle long.
   input wire logic dev_rst_req,
   // Mode and source of the current access.
   input wire logic in_circuit_programming_mode,
   input wire logic from_debug_link,
   // Byte access port into the option byte row.
   input wire logic acc_req,
   input wire logic acc_we,
   input wire logic [ADDR_W-1:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   output logic [7:0] acc_rdata,
   output logic acc_rvalid,
   output logic acc_refused,
   // Decoded configuration.
   output obc_cfg_t cfg,
   output logic cfg_valid
);

   // The address decode needs at least the sixteen printed address bits.
   if (ADDR_W < 16)
   begin : g_bad_width
      $error("ADDR_W must be at least 16");
   end

   // Stored option byte row, kept across device resets.
   logic [OBC_ROW_BYTES-1:0][7:0] row;
   logic [OBC_ROW_BYTES-1:0][7:0] next_row;
   // Access port answer registers.
   logic [7:0] next_acc_rdata;
   logic next_acc_rvalid;
   logic next_acc_refused;
   // Loader state and decoded configuration.
   obc_state_t state;
   obc_state_t next_state;
   obc_cfg_t next_cfg;
   logic next_cfg_valid;
   // Address decode results.
   logic hit;
   logic [2:0] idx;
   logic write_ok;

   // Maps the access address onto a row index.
   always_comb
   begin
      hit = 1'b1;
      idx = OBC_IDX_PROTECTION;
      if ((acc_addr >> 16) != '0)
      begin
         // Upper address bits select nothing here.
         hit = 1'b0;
      end
      else
      begin
         case (acc_addr[15:0])
            OBC_ADDR_PROTECTION: idx = OBC_IDX_PROTECTION;
            OBC_ADDR_BOOT_SIZE: idx = OBC_IDX_BOOT_SIZE;
            OBC_ADDR_EEPROM_SIZE: idx = OBC_IDX_EEPROM_SIZE;
            OBC_ADDR_RESERVED: idx = OBC_IDX_RESERVED;
            OBC_ADDR_WATCHDOG: idx = OBC_IDX_WATCHDOG;
            default: hit = 1'b0;
         endcase
      end
   end

   assign write_ok = in_circuit_programming_mode && from_debug_link && hit;

   // Computes row updates and the access answer.
   always_comb
   begin
      next_row = row;
      next_acc_rdata = 8'h00;
      next_acc_rvalid = 1'b0;
      next_acc_refused = 1'b0;
      if (acc_req && acc_we)
      begin
         if (write_ok)
         begin
            next_row[idx] = acc_wdata;
         end
         else
         begin
            next_acc_refused = 1'b1;
         end
      end
      else if (acc_req)
      begin
         // Reads return the stored byte; unmapped addresses read as zero.
         next_acc_rvalid = 1'b1;
         if (hit)
         begin
            next_acc_rdata = row[idx];
         end
      end
   end

   // Registers the row and the access answer.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         row <= {OBC_ROW_BYTES{OBC_BYTE_DEFAULT}};
         acc_rdata <= 8'h00;
         acc_rvalid <= 1'b0;
         acc_refused <= 1'b0;
      end
      else
      begin
         row <= next_row;
         acc_rdata <= next_acc_rdata;
         acc_rvalid <= next_acc_rvalid;
         acc_refused <= next_acc_refused;
      end
   end

   // Decodes the stored row into configuration at each load.
   always_comb
   begin
      logic [6:0] boot_n;
      logic [5:0] ee_n;
      boot_n = row[OBC_IDX_BOOT_SIZE][OBC_BOOT_SIZE_BITS-1:0];
      ee_n = row[OBC_IDX_EEPROM_SIZE][OBC_EEPROM_SIZE_BITS-1:0];
      next_state = state;
      next_cfg = cfg;
      next_cfg_valid = cfg_valid;
      case (state)
         OBC_LOAD:
         begin
            next_state = OBC_HOLD;
            next_cfg_valid = 1'b1;
            next_cfg.readout_protect = (row[OBC_IDX_PROTECTION] == OBC_READOUT_LOCK_CODE);
            next_cfg.boot_present = (boot_n != 7'h00);
            next_cfg.boot_vectors_only = (boot_n != 7'h00) && (boot_n < OBC_BOOT_FIRST_PROTECTED);
            next_cfg.boot_write_protect = (boot_n >= OBC_BOOT_FIRST_PROTECTED);
            if (boot_n >= OBC_BOOT_FIRST_PROTECTED)
            begin
               next_cfg.boot_pages = boot_n;
            end
            else if (boot_n != 7'h00)
            begin
               next_cfg.boot_pages = OBC_BOOT_VECTOR_PAGES;
            end
            else
            begin
               next_cfg.boot_pages = 7'h00;
            end
            next_cfg.eeprom_pages = ee_n;
            next_cfg.eeprom_present = (ee_n != 6'h00);
            next_cfg.eeprom_base = OBC_EEPROM_END - {4'h0, ee_n, 6'h00};
            next_cfg.watchdog_auto_start = row[OBC_IDX_WATCHDOG][OBC_WDG_AUTO_START_BIT];
            next_cfg.watchdog_halt_freeze = row[OBC_IDX_WATCHDOG][OBC_WDG_HALT_FREEZE_BIT];
         end
         OBC_HOLD:
         begin
            if (dev_rst_req)
            begin
               next_state = OBC_LOAD;
            end
         end
         default:
         begin
            next_state = OBC_LOAD;
         end
      endcase
   end

   // Registers loader state and configuration; power-on starts a load.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= OBC_LOAD;
         cfg <= '0;
         cfg_valid <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cfg <= next_cfg;
         cfg_valid <= next_cfg_valid;
      end
   end

   // Checks that guard the write path and the decoder.
   AST_WRITE_GUARD:
   assert property (@(posedge clk) disable iff (!arst_n)
      (acc_req && acc_we && !(in_circuit_programming_mode && from_debug_link))
      |=> $stable(row) && acc_refused)
   else $error("option row changed by a refused write");

   AST_WRITE_TAKEN:
   assert property (@(posedge clk) disable iff (!arst_n)
      (acc_req && acc_we && write_ok) |=> row[$past(idx)] == $past(acc_wdata) && !acc_refused)
   else $error("permitted option write not stored");

   AST_READOUT:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_LOAD)
      |=> cfg.readout_protect == ($past(row[OBC_IDX_PROTECTION]) == 8'hAA))
   else $error("readout protection does not match lock code");

   AST_BOOT_SMALL:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_LOAD && row[OBC_IDX_BOOT_SIZE][6:0] < 7'h03)
      |=> !cfg.boot_write_protect && cfg.boot_vectors_only == cfg.boot_present)
   else $error("small boot size decoded wrongly");

   AST_BOOT_LARGE:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_LOAD && row[OBC_IDX_BOOT_SIZE][6:0] >= 7'h03)
      |=> cfg.boot_write_protect && cfg.boot_pages == $past(row[OBC_IDX_BOOT_SIZE][6:0]))
   else $error("boot area pages wrong");

   AST_BOOT_MSB:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_LOAD && row[OBC_IDX_BOOT_SIZE] == 8'h80)
      |=> !cfg.boot_present && cfg.boot_pages == 7'h00)
   else $error("boot size top bit not ignored");

   AST_EEPROM_NONE:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_LOAD && row[OBC_IDX_EEPROM_SIZE][5:0] == 6'h00)
      |=> !cfg.eeprom_present && cfg.eeprom_base == 16'hA000)
   else $error("zero EEPROM size allocated an area");

   AST_EEPROM_BASE:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_LOAD)
      |=> cfg.eeprom_base + {4'h0, cfg.eeprom_pages, 6'h00} - 16'h0001 == OBC_EEPROM_TOP)
   else $error("EEPROM area does not end at its top");

   AST_EEPROM_MSB:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_LOAD) |=> cfg.eeprom_pages == $past(row[OBC_IDX_EEPROM_SIZE][5:0]))
   else $error("EEPROM size top bits not dropped");

   AST_WATCHDOG:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_LOAD)
      |=> cfg.watchdog_auto_start == $past(row[OBC_IDX_WATCHDOG][0])
      && cfg.watchdog_halt_freeze == $past(row[OBC_IDX_WATCHDOG][1]))
   else $error("watchdog options decoded wrongly");

   AST_HOLD:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_HOLD) |=> $stable(cfg) && cfg_valid)
   else $error("configuration changed between resets");

   // A read never touches the row and is always answered, never refused.
   AST_READ_ANSWER:
   assert property (@(posedge clk) disable iff (!arst_n)
      (acc_req && !acc_we) |=> acc_rvalid && !acc_refused && $stable(row))
   else $error("read access not answered or changed the row");

   // A write outside the option row is refused even in programming mode.
   AST_UNMAPPED_WRITE:
   assert property (@(posedge clk) disable iff (!arst_n)
      (acc_req && acc_we && !hit) |=> acc_refused && $stable(row))
   else $error("write to an unmapped address was not refused");

   // A load finishes in one cycle and leaves the configuration valid.
   AST_LOAD_DONE:
   assert property (@(posedge clk) disable iff (!arst_n)
      (state == OBC_LOAD) |=> state == OBC_HOLD && cfg_valid)
   else $error("load did not complete in one cycle");

endmodule
`default_nettype wire

// ==== obc_programmer_model.sv ====
// Model of the external programming tool on the option row access port.
// Assumes the bench calls its tasks and that clk is the device clock.
`timescale 1ns/1ps
`default_nettype none
module obc_programmer_model
(
   // Device clock.
   input wire logic clk,
   // Mode and source of every access.
   output logic in_circuit_programming_mode,
   output logic from_debug_link,
   // Byte access port.
   output logic acc_req,
   output logic acc_we,
   output logic [15:0] acc_addr,
   output logic [7:0] acc_wdata,
   input wire logic [7:0] acc_rdata,
   input wire logic acc_rvalid,
   input wire logic acc_refused
);
   // The tool starts idle and outside programming mode.
   initial
   begin
      in_circuit_programming_mode = 1'b0;
      from_debug_link = 1'b0;
      acc_req = 1'b0;
      acc_we = 1'b0;
      acc_addr = 16'h0000;
      acc_wdata = 8'h00;
   end
   task automatic set_path(input logic mode, input logic link);
      @(negedge clk);
      in_circuit_programming_mode = mode;
      from_debug_link = link;
   endtask
   // byte access.
   // The request is held across one rising edge, then the bus shows junk.
   task automatic access(input logic we, input logic [15:0] addr, input logic [7:0] wdata,
      output logic [7:0] rdata, output logic rvalid, output logic refused);
      @(negedge clk);
      acc_req = 1'b1;
      acc_we = we;
      acc_addr = addr;
      acc_wdata = wdata;
      @(negedge clk);
      rdata = acc_rdata;
      rvalid = acc_rvalid;
      refused = acc_refused;
      acc_req = 1'b0;
      acc_addr = ~addr;
      acc_wdata = ~wdata;
   endtask
endmodule
`default_nettype wire

// ==== obc_option_decoder_bench.sv ====
// Self-checking bench for the option byte decoder with a row model.
// Assumes the programmer model drives the access port.
`timescale 1ns/1ps
`default_nettype none
module obc_option_decoder_bench;
   import obc_pkg::*;
   logic clk;
   logic arst_n;
   logic dev_rst_req;
   logic mode;
   logic link;
   logic acc_req;
   logic acc_we;
   logic [15:0] acc_addr;
   logic [7:0] acc_wdata;
   logic [7:0] acc_rdata;
   logic acc_rvalid;
   logic acc_refused;
   obc_cfg_t cfg;
   obc_cfg_t loaded;
   logic cfg_valid;
   logic [7:0] rd;
   logic rv;
   logic rf;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   int row [5];
   integer seed = 32'hf2976b20;
   logic [31:0] table_v [8] = '{32'hAA00_0000, 32'hAB01_0101, 32'hAA02_2002, 32'h0003_3F03,
      32'hAA7F_C100, 32'h5580_4001, 32'hAAFF_FF02, 32'h0081_8003};
   obc_option_decoder #(.ADDR_W(16)) dut (.clk(clk), .arst_n(arst_n), .dev_rst_req(dev_rst_req),
      .in_circuit_programming_mode(mode), .from_debug_link(link), .acc_req(acc_req),
      .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
      .acc_rvalid(acc_rvalid), .acc_refused(acc_refused), .cfg(cfg), .cfg_valid(cfg_valid));
   obc_programmer_model prog (.clk(clk), .in_circuit_programming_mode(mode),
      .from_debug_link(link), .acc_req(acc_req), .acc_we(acc_we), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
      .acc_refused(acc_refused));
   // Free-running 200 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Cuts a hang short.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         failures++;
         end_of_test();
      end
   end
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Row slot of a byte address, or -1 when unmapped.
   function automatic int slot(input logic [15:0] a);
      case (a)
         OBC_ADDR_PROTECTION: return 0;
         OBC_ADDR_BOOT_SIZE: return 1;
         OBC_ADDR_EEPROM_SIZE: return 2;
         OBC_ADDR_RESERVED: return 3;
         OBC_ADDR_WATCHDOG: return 4;
         default: return -1;
      endcase
   endfunction
   // Decoded configuration expected from the model row.
   function automatic obc_cfg_t model_cfg();
      obc_cfg_t c;
      int b;
      int e;
      b = row[1] % 128;
      e = row[2] % 64;
      c.readout_protect = (row[0] == 170);
      c.boot_present = (b != 0);
      c.boot_vectors_only = (b == 1 || b == 2);
      c.boot_write_protect = (b >= 3);
      c.boot_pages = 7'((b == 1 || b == 2) ? 2 : b);
      c.eeprom_present = (e != 0);
      c.eeprom_pages = 6'(e);
      c.eeprom_base = 16'(40960 - e * 64);
      c.watchdog_auto_start = row[4][0];
      c.watchdog_halt_freeze = row[4][1];
      return c;
   endfunction
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic refuse);
      prog.access(1'b1, a, d, rd, rv, rf);
      check("acc_refused", rf, refuse);
      check("acc_rvalid", rv, 1'b0);
      if (!refuse && slot(a) >= 0)
         row[slot(a)] = d;
   endtask
   task automatic rdc(input logic [15:0] a);
      prog.access(1'b0, a, 8'h00, rd, rv, rf);
      check("acc_rvalid", rv, 1'b1);
      check("acc_refused", rf, 1'b0);
      check("acc_rdata", rd, (slot(a) >= 0) ? row[slot(a)] : 0);
   endtask
   // Device reset pulse; the new configuration lands at the second rising edge.
   task automatic reload();
      @(negedge clk);
      dev_rst_req = 1'b1;
      @(negedge clk);
      dev_rst_req = 1'b0;
      check("cfg before load", cfg, loaded);
      @(negedge clk);
      loaded = model_cfg();
      check("cfg", cfg, loaded);
      check("cfg_valid", cfg_valid, 1'b1);
   endtask
   initial
   begin
      arst_n = 1'b0;
      dev_rst_req = 1'b0;
      row = '{default: 0};
      repeat (10) @(negedge clk);
      check("cfg_valid", cfg_valid, 1'b0);
      arst_n = 1'b1;
      @(negedge clk);
      loaded = model_cfg();
      check("cfg at start", cfg, loaded);
      check("cfg_valid", cfg_valid, 1'b1);
      for (int i = 0; i < 5; i++)
         rdc(16'h4800 + 16'(i));
      $display("test reset done");
      // Writes from any other mode or source are refused.
      for (int m = 0; m < 3; m++)
      begin
         prog.set_path(m[0], m[1]);
         wr(OBC_ADDR_PROTECTION, 8'hAA, 1'b1);
      end
      prog.set_path(1'b1, 1'b1);
      wr(16'h4801, 8'h55, 1'b1);
      rdc(OBC_ADDR_PROTECTION);
      $display("test refusal done");
      // Table values first, then random bytes.
      for (int i = 0; i < 24; i++)
      begin
         logic [31:0] v;
         v = (i < 8) ? table_v[i] : $random(seed);
         wr(OBC_ADDR_PROTECTION, v[31:24], 1'b0);
         wr(OBC_ADDR_BOOT_SIZE, v[23:16], 1'b0);
         wr(OBC_ADDR_EEPROM_SIZE, v[15:8], 1'b0);
         wr(OBC_ADDR_WATCHDOG, v[7:0], 1'b0);
         wr(OBC_ADDR_RESERVED, 8'h00, 1'b0);
         rdc(OBC_ADDR_BOOT_SIZE);
         check("cfg held", cfg, loaded);
         reload();
      end
      $display("test decode done");
      // A second power-on reset in mid-run clears the row.
      @(negedge clk);
      arst_n = 1'b0;
      @(negedge clk);
      check("cfg_valid", cfg_valid, 1'b0);
      arst_n = 1'b1;
      row = '{default: 0};
      @(negedge clk);
      loaded = model_cfg();
      check("cfg after reset", cfg, loaded);
      rdc(OBC_ADDR_WATCHDOG);
      $display("test second reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
